// ### rtl/dif_pkg.sv
// Operation
// - three selects decode binary, bit2 most significant
// - selected data set supplies speed, ramp, torque
// - per-output polarity: active closed or open
// - function 1 speed pulse, twelve per rev
// - function 2 active while alarm present
// - function 3 active while motor energized
// - function 4 active inside speed window while motor running
// - function 5 active above over threshold
// - function 6 pulses the alarm code
// - function 7 energized, then alarm pulses
// - function 11 active while motor operating
// - function 12 active during CCW rotation
// - function 15 window but off when stationary
// - function 16 window, gated after stop
// - function 13 drives holding brake, high-current
// - function 0 holds output inactive
// - run command from lines or network
// - source 0 takes potentiometer speed
// - alarm removes drive and flags alarm
package dif_pkg;
  // clock rate
  localparam int CLK_MHZ = 10;
  // field widths
  localparam int SPEED_W = 14;           // speed in r/min, up to 10000
  localparam int RAMP_W = 16;            // accel/decel time
  localparam int TORQUE_W = 8;           // torque limit
  localparam int FUNC_W = 5;             // output function code
  localparam int CODE_W = 4;             // alarm code
  localparam int SRC_W = 3;              // command source selector
  localparam int SEL_W = 3;              // operation data number
  localparam int NUM_SETS = 8;           // stored operation data sets
  localparam int NUM_OUT = 5;            // Y1, Y2, YH, OUT1, OUT2
  localparam int FIRST_HC = 3;           // first high-current output index
  // output function codes
  localparam logic [FUNC_W-1:0] FN_UNUSED = 5'h00;
  localparam logic [FUNC_W-1:0] FN_SPEED_PULSE = 5'h01;
  localparam logic [FUNC_W-1:0] FN_ALARM = 5'h02;
  localparam logic [FUNC_W-1:0] FN_ENERGIZED = 5'h03;
  localparam logic [FUNC_W-1:0] FN_REACHED = 5'h04;
  localparam logic [FUNC_W-1:0] FN_OVER = 5'h05;
  localparam logic [FUNC_W-1:0] FN_ALARM_PULSE = 5'h06;
  localparam logic [FUNC_W-1:0] FN_ENERGIZED_OR_ALARM = 5'h07;
  localparam logic [FUNC_W-1:0] FN_RUN = 5'h0b;
  localparam logic [FUNC_W-1:0] FN_DIR = 5'h0c;
  localparam logic [FUNC_W-1:0] FN_BRAKE = 5'h0d;
  localparam logic [FUNC_W-1:0] FN_REACHED_MOVING = 5'h0f;
  localparam logic [FUNC_W-1:0] FN_REACHED_OR_OVER = 5'h10;
  // command source values
  localparam logic [SRC_W-1:0] SRC_POT = 3'h0;
  localparam logic [SRC_W-1:0] SRC_ANALOG = 3'h4;
  // reset values
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [SPEED_W-1:0] SPEED_RESET = 14'h0000;
  localparam logic [RAMP_W-1:0] RAMP_RESET = 16'h0000;
  localparam logic [TORQUE_W-1:0] TORQUE_RESET = 8'h00;
  // alarm pulse timing, in microseconds
  localparam int ALM_HALF_US = 5000;     // high and low time of one code pulse
  localparam int ALM_GAP_US = 20000;     // pause between two code bursts
  localparam int ALM_HALF_CYC = ALM_HALF_US * CLK_MHZ;
  localparam int ALM_GAP_CYC = ALM_GAP_US * CLK_MHZ;
  localparam int TIMER_W = 24;           // holds the longest timing count
endpackage : dif_pkg

// ### rtl/dif_alarm_pulse.sv
`timescale 1ns/1ps
module dif_alarm_pulse #(
  parameter int HALF_CYC = dif_pkg::ALM_HALF_CYC,  // code pulse high and low time
  parameter int GAP_CYC = dif_pkg::ALM_GAP_CYC     // pause after each burst
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic alarm,
  input wire logic [dif_pkg::CODE_W-1:0] code,
  output logic pulse
);
  import dif_pkg::*;

  typedef enum logic [1:0] {DIFP_IDLE, DIFP_HIGH, DIFP_LOW, DIFP_GAP} difp_state_e;

  difp_state_e state;                     // burst sequencer
  logic [TIMER_W-1:0] timer;              // cycles left in current phase
  logic [CODE_W-1:0] left;                // pulses still to send in burst

  // burst = code pulses then a gap; code latched per burst so a change
  // mid-burst never produces a mangled count
  always_ff @(posedge clk) begin
    if (rst || !alarm) begin
      state <= DIFP_IDLE;
      timer <= '0;
      left <= '0;
      pulse <= 1'b0;
    end else begin
      case (state)
        DIFP_IDLE: begin
          left <= code;
          pulse <= 1'b0;
          timer <= TIMER_W'(GAP_CYC - 1);
          state <= DIFP_GAP;
          if (code != '0) begin
            pulse <= 1'b1;
            left <= code - 1'b1;
            timer <= TIMER_W'(HALF_CYC - 1);
            state <= DIFP_HIGH;
          end
        end
        DIFP_HIGH: begin
          if (timer == '0) begin
            pulse <= 1'b0;
            timer <= TIMER_W'(HALF_CYC - 1);
            state <= DIFP_LOW;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        DIFP_LOW: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (left != '0) begin // more pulses in this burst
            left <= left - 1'b1;
            pulse <= 1'b1;
            timer <= TIMER_W'(HALF_CYC - 1);
            state <= DIFP_HIGH;
          end else begin
            timer <= TIMER_W'(GAP_CYC - 1);
            state <= DIFP_GAP;
          end
        end
        DIFP_GAP: begin
          if (timer == '0) begin
            state <= DIFP_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: begin
          state <= DIFP_IDLE;
        end
      endcase
    end
  end
endmodule : dif_alarm_pulse

// ### rtl/dif_top.sv
`timescale 1ns/1ps
module dif_top #(
  parameter int ALM_HALF_CYC = dif_pkg::ALM_HALF_CYC,  // code pulse half period
  parameter int ALM_GAP_CYC = dif_pkg::ALM_GAP_CYC     // pause between bursts
) (
  input wire logic CLK,
  input wire logic RST,
  // operation data number selects, from the controller
  input wire logic INDEX_SEL_BIT0,
  input wire logic INDEX_SEL_BIT1,
  input wire logic INDEX_SEL_BIT2,
  // operation data table write port
  input wire logic DATA_WR,
  input wire logic [dif_pkg::SEL_W-1:0] DATA_WR_NO,
  input wire logic [dif_pkg::SPEED_W-1:0] DATA_WR_SPEED,
  input wire logic [dif_pkg::RAMP_W-1:0] DATA_WR_RAMP,
  input wire logic [dif_pkg::TORQUE_W-1:0] DATA_WR_TORQUE,
  // speed command source and analog speed values
  input wire logic [dif_pkg::SRC_W-1:0] CMD_SOURCE,
  input wire logic [dif_pkg::SPEED_W-1:0] ONBOARD_POTENTIOMETER,
  input wire logic [dif_pkg::SPEED_W-1:0] ANALOG_SPEED,
  // run command sources
  input wire logic RUN_CMD_IO,
  input wire logic RUN_CMD_NET,
  input wire logic RUN_FROM_NET,
  // motor status from the drive core
  input wire logic MOTOR_ENERGIZED,
  input wire logic MOTOR_RUNNING,
  input wire logic DIR_CCW,
  input wire logic HALL_EDGE,
  input wire logic [dif_pkg::SPEED_W-1:0] MEAS_SPEED,
  input wire logic [dif_pkg::SPEED_W-1:0] REACH_BAND,
  input wire logic [dif_pkg::SPEED_W-1:0] OVER_SPEED,
  input wire logic ALARM_PRESENT,
  input wire logic [dif_pkg::CODE_W-1:0] ALARM_CODE,
  // output configuration, one field per output
  input wire logic [dif_pkg::NUM_OUT*dif_pkg::FUNC_W-1:0] OUT_FUNC,
  input wire logic [dif_pkg::NUM_OUT-1:0] OUT_ACTIVE_OPEN,
  // results
  output logic [dif_pkg::SEL_W-1:0] DATA_NO,
  output logic [dif_pkg::SPEED_W-1:0] SEL_SPEED,
  output logic [dif_pkg::RAMP_W-1:0] SEL_RAMP,
  output logic [dif_pkg::TORQUE_W-1:0] SEL_TORQUE,
  output logic [dif_pkg::SPEED_W-1:0] CMD_SPEED,
  output logic RUN_REQUEST,
  output logic MOTOR_DRIVE_EN,
  output logic ALARM_ACTIVE_OUTPUT,
  output logic [dif_pkg::NUM_OUT-1:0] OUT_CLOSED
);
  import dif_pkg::*;

  // select synchroniser stages; stage one feeds stage two only
  logic [SEL_W-1:0] sel_meta;
  logic [SEL_W-1:0] sel_sync;

  // operation data storage, one entry per data number
  logic [SPEED_W-1:0] set_speed [NUM_SETS];
  logic [RAMP_W-1:0] set_ramp [NUM_SETS];
  logic [TORQUE_W-1:0] set_torque [NUM_SETS];

  // derived status
  logic speed_pulse_output;               // toggles on each commutation edge
  logic alarm_code_pulse_output;          // alarm code burst pattern
  logic [SPEED_W-1:0] speed_diff;         // distance from target speed
  logic speed_reached;                    // motor running and inside the window
  logic speed_over;                       // above over threshold
  logic stopped_after_cmd;                // a stop command has been seen
  logic run_cmd;                          // selected run command
  logic run_cmd_d;                        // previous run command, for edges
  logic holding_brake_output;             // high = brake released
  logic [NUM_OUT-1:0] func_state;         // logical state before polarity

  // two-flop synchroniser on the selects, bit2 most significant
  always_ff @(posedge CLK) begin
    if (RST) begin
      sel_meta <= SEL_RESET;
      sel_sync <= SEL_RESET;
    end else begin
      sel_meta <= {INDEX_SEL_BIT2, INDEX_SEL_BIT1, INDEX_SEL_BIT0};
      sel_sync <= sel_meta;
    end
  end

  // data table write; table is not reset, software loads it after power up
  always_ff @(posedge CLK) begin
    if (DATA_WR) begin
      set_speed[DATA_WR_NO] <= DATA_WR_SPEED;
      set_ramp[DATA_WR_NO] <= DATA_WR_RAMP;
      set_torque[DATA_WR_NO] <= DATA_WR_TORQUE;
    end
  end

  // the selected set drives the speed, ramp and torque outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      DATA_NO <= SEL_RESET;
      SEL_SPEED <= SPEED_RESET;
      SEL_RAMP <= RAMP_RESET;
      SEL_TORQUE <= TORQUE_RESET;
    end else begin
      DATA_NO <= sel_sync;
      SEL_SPEED <= set_speed[sel_sync];
      SEL_RAMP <= set_ramp[sel_sync];
      SEL_TORQUE <= set_torque[sel_sync];
    end
  end

  // speed command source; ramp and torque still come from the data set
  always_ff @(posedge CLK) begin
    if (RST) begin
      CMD_SPEED <= SPEED_RESET;
    end else begin
      case (CMD_SOURCE)
        SRC_POT: begin
          CMD_SPEED <= ONBOARD_POTENTIOMETER;
        end
        SRC_ANALOG: begin
          CMD_SPEED <= ANALOG_SPEED;
        end
        default: begin
          CMD_SPEED <= set_speed[sel_sync];
        end
      endcase
    end
  end

  // run command from discrete line or network virtual input
  assign run_cmd = RUN_FROM_NET ? RUN_CMD_NET : RUN_CMD_IO;

  // an alarm forces the drive off so the motor coasts
  always_ff @(posedge CLK) begin
    if (RST) begin
      RUN_REQUEST <= 1'b0;
      MOTOR_DRIVE_EN <= 1'b0;
      ALARM_ACTIVE_OUTPUT <= 1'b0;
    end else begin
      RUN_REQUEST <= run_cmd;
      MOTOR_DRIVE_EN <= run_cmd && !ALARM_PRESENT;
      ALARM_ACTIVE_OUTPUT <= ALARM_PRESENT;
    end
  end

  // remembers a stop command until the next run command
  always_ff @(posedge CLK) begin
    if (RST) begin
      run_cmd_d <= 1'b0;
      stopped_after_cmd <= 1'b1;
    end else begin
      run_cmd_d <= run_cmd;
      if (run_cmd && !run_cmd_d) begin
        stopped_after_cmd <= 1'b0;
      end else if (!run_cmd && run_cmd_d) begin
        stopped_after_cmd <= 1'b1;
      end
    end
  end

  // speed pulse: one half period per commutation edge, so the pulse
  // count per revolution follows the pole count on its own
  always_ff @(posedge CLK) begin
    if (RST) begin
      speed_pulse_output <= 1'b0;
    end else if (HALL_EDGE) begin
      speed_pulse_output <= !speed_pulse_output;
    end
  end

  // speed window and over-speed comparators
  assign speed_diff = (MEAS_SPEED >= CMD_SPEED) ? (MEAS_SPEED - CMD_SPEED)
                                                : (CMD_SPEED - MEAS_SPEED);
  assign speed_reached = MOTOR_RUNNING && (speed_diff <= REACH_BAND);
  assign speed_over = MEAS_SPEED > OVER_SPEED;

  // brake released only while powered and alarm free; locked otherwise
  assign holding_brake_output = MOTOR_ENERGIZED && !ALARM_PRESENT;

  // alarm code pulse generator
  dif_alarm_pulse #(
    .HALF_CYC(ALM_HALF_CYC),
    .GAP_CYC(ALM_GAP_CYC)
  ) u_alarm_pulse (
    .clk(CLK),
    .rst(RST),
    .alarm(ALARM_PRESENT),
    .code(ALARM_CODE),
    .pulse(alarm_code_pulse_output)
  );

  // per-output function mux and polarity stage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      logic [FUNC_W-1:0] fn;              // this output's function code
      assign fn = OUT_FUNC[gi*FUNC_W +: FUNC_W];

      // logical state of the assigned function
      always_comb begin
        case (fn)
          FN_UNUSED: begin
            func_state[gi] = 1'b0;
          end
          FN_SPEED_PULSE: begin
            func_state[gi] = speed_pulse_output;
          end
          FN_ALARM: begin
            func_state[gi] = ALARM_PRESENT;
          end
          FN_ENERGIZED: begin
            func_state[gi] = MOTOR_ENERGIZED;
          end
          FN_REACHED: begin
            func_state[gi] = speed_reached;
          end
          FN_OVER: begin
            func_state[gi] = speed_over;
          end
          FN_ALARM_PULSE: begin
            func_state[gi] = ALARM_PRESENT && alarm_code_pulse_output;
          end
          FN_ENERGIZED_OR_ALARM: begin
            func_state[gi] = ALARM_PRESENT ? alarm_code_pulse_output : MOTOR_ENERGIZED;
          end
          FN_RUN: begin
            func_state[gi] = MOTOR_RUNNING;
          end
          FN_DIR: begin
            func_state[gi] = MOTOR_RUNNING && DIR_CCW;
          end
          FN_BRAKE: begin
            // brake coil needs current, so low-current outputs ignore it
            func_state[gi] = (gi >= FIRST_HC) && holding_brake_output;
          end
          FN_REACHED_MOVING: begin
            func_state[gi] = (MEAS_SPEED != '0) && speed_reached;
          end
          FN_REACHED_OR_OVER: begin
            func_state[gi] = stopped_after_cmd ? (speed_over && speed_reached)
                                               : speed_reached;
          end
          default: begin
            func_state[gi] = 1'b0;        // codes with no function stay inactive
          end
        endcase
      end

      // polarity last, so every function shares one inversion point
      always_ff @(posedge CLK) begin
        if (RST) begin
          OUT_CLOSED[gi] <= 1'b0;
        end else begin
          OUT_CLOSED[gi] <= func_state[gi] ^ OUT_ACTIVE_OPEN[gi];
        end
      end
    end
  endgenerate
endmodule : dif_top

// ### dv/dif_properties.sv
`timescale 1ns/1ps
module dif_properties #(
  parameter int ALM_HALF_CYC = 4,
  parameter int ALM_GAP_CYC = 10
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic INDEX_SEL_BIT0,
  input wire logic INDEX_SEL_BIT1,
  input wire logic INDEX_SEL_BIT2,
  input wire logic [dif_pkg::SRC_W-1:0] CMD_SOURCE,
  input wire logic [dif_pkg::SPEED_W-1:0] ONBOARD_POTENTIOMETER,
  input wire logic RUN_CMD_IO,
  input wire logic RUN_CMD_NET,
  input wire logic RUN_FROM_NET,
  input wire logic MOTOR_ENERGIZED,
  input wire logic HALL_EDGE,
  input wire logic ALARM_PRESENT,
  input wire logic [dif_pkg::NUM_OUT*dif_pkg::FUNC_W-1:0] OUT_FUNC,
  input wire logic [dif_pkg::NUM_OUT-1:0] OUT_ACTIVE_OPEN,
  input wire logic [dif_pkg::SEL_W-1:0] DATA_NO,
  input wire logic [dif_pkg::SPEED_W-1:0] CMD_SPEED,
  input wire logic RUN_REQUEST,
  input wire logic MOTOR_DRIVE_EN,
  input wire logic ALARM_ACTIVE_OUTPUT,
  input wire logic [dif_pkg::NUM_OUT-1:0] OUT_CLOSED
);
  import dif_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic [1:0] up;  // edges since reset release, saturating
  logic pls;  // output 0 set to the speed pulse
  assign pls = OUT_FUNC[4:0] == FN_SPEED_PULSE;
  // history from before release is stale, so checks wait on this age
  always_ff @(posedge CLK) begin
    if (RST) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  a_drive_en_gate: assert property (
    MOTOR_DRIVE_EN == (RUN_REQUEST && !ALARM_ACTIVE_OUTPUT))
    else $error("drive enable not gated");
  a_alarm_flag: assert property (up != 2'h0 |->
    ALARM_ACTIVE_OUTPUT == $past(ALARM_PRESENT))
    else $error("alarm flag wrong");
  a_run_source: assert property (up != 2'h0 |->
    RUN_REQUEST == $past(RUN_FROM_NET ? RUN_CMD_NET : RUN_CMD_IO))
    else $error("run source wrong");
  a_sel_decode: assert property (up == 2'h3 |->
    DATA_NO == $past({INDEX_SEL_BIT2, INDEX_SEL_BIT1, INDEX_SEL_BIT0}, 3))
    else $error("data number wrong");
  a_pot_source: assert property (up != 2'h0 && $past(CMD_SOURCE) == SRC_POT |->
    CMD_SPEED == $past(ONBOARD_POTENTIOMETER))
    else $error("speed source wrong");
  a_unused_idle: assert property (up != 2'h0 &&
    $past(OUT_FUNC[4:0]) == FN_UNUSED |-> OUT_CLOSED[0] == $past(OUT_ACTIVE_OPEN[0]))
    else $error("unused output not idle");
  a_brake_hc: assert property (up != 2'h0 && $past(OUT_FUNC[19:15]) == FN_BRAKE |->
    OUT_CLOSED[3] == $past((MOTOR_ENERGIZED && !ALARM_PRESENT) ^ OUT_ACTIVE_OPEN[3]))
    else $error("brake output wrong");
  a_speed_toggle: assert property (up == 2'h3 && $past(pls) && $past(pls, 2)
    && $past(OUT_ACTIVE_OPEN[0]) == $past(OUT_ACTIVE_OPEN[0], 2)
    |-> OUT_CLOSED[0] == ($past(OUT_CLOSED[0]) ^ $past(HALL_EDGE, 2)))
    else $error("speed pulse wrong");
  c_data_seven: cover property (DATA_NO == 3'h7);
  c_alarm_burst: cover property ($rose(OUT_CLOSED[0]) && ALARM_ACTIVE_OUTPUT);
  c_drive_on: cover property (MOTOR_DRIVE_EN);
endmodule : dif_properties
bind dif_top dif_properties #(.ALM_HALF_CYC(ALM_HALF_CYC), .ALM_GAP_CYC(ALM_GAP_CYC))
  i_dif_properties (.CLK(CLK), .RST(RST), .INDEX_SEL_BIT0(INDEX_SEL_BIT0),
  .INDEX_SEL_BIT1(INDEX_SEL_BIT1), .INDEX_SEL_BIT2(INDEX_SEL_BIT2), .CMD_SOURCE(CMD_SOURCE),
  .ONBOARD_POTENTIOMETER(ONBOARD_POTENTIOMETER), .RUN_CMD_IO(RUN_CMD_IO),
  .RUN_CMD_NET(RUN_CMD_NET), .RUN_FROM_NET(RUN_FROM_NET), .MOTOR_ENERGIZED(MOTOR_ENERGIZED),
  .HALL_EDGE(HALL_EDGE), .ALARM_PRESENT(ALARM_PRESENT), .OUT_FUNC(OUT_FUNC),
  .OUT_ACTIVE_OPEN(OUT_ACTIVE_OPEN), .DATA_NO(DATA_NO), .CMD_SPEED(CMD_SPEED),
  .RUN_REQUEST(RUN_REQUEST), .MOTOR_DRIVE_EN(MOTOR_DRIVE_EN),
  .ALARM_ACTIVE_OUTPUT(ALARM_ACTIVE_OUTPUT), .OUT_CLOSED(OUT_CLOSED));

// ### dv/dif_ctrl_model.sv
`timescale 1ns/1ps
// controller on the discrete lines: selects and run commands
module dif_ctrl_model (
  input wire logic clk,
  input wire logic [2:0] want_no,
  input wire logic want_run,
  input wire logic use_net,
  output logic sel0,
  output logic sel1,
  output logic sel2,
  output logic run_io,
  output logic run_net,
  output logic from_net
);
  // lines idle off at power up
  initial {sel2, sel1, sel0, run_io, run_net, from_net} = 6'h00;
  // levels change just after an edge, one edge behind the request
  always @(posedge clk) begin
    {sel2, sel1, sel0} <= want_no;
    from_net <= use_net;
    // unselected source shows the opposite, so a wrong pick shows
    run_io <= use_net ? !want_run : want_run;
    run_net <= use_net ? want_run : !want_run;
  end
endmodule : dif_ctrl_model

// ### dv/test_dif_top.sv
`timescale 1ns/1ps
module test_dif_top;
  import dif_pkg::*;
  typedef struct {int cyc; int kind; logic [37:0] val;} dif_note_s;
  dif_note_s notes[$];  // expected results, oldest first
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] want_no = 3'h0;
  logic want_run = 1'b0;
  logic use_net = 1'b0;
  logic sel0, sel1, sel2, run_io, run_net, from_net;
  logic wr = 1'b0;
  logic [2:0] wr_no = 3'h0;
  logic [37:0] wr_set = 38'h0;  // speed, ramp, torque
  logic [2:0] src = 3'h0;
  logic [13:0] pot = 14'h0, ana = 14'h0, meas = 14'h0, band = 14'h0, over = 14'h0;
  logic ener = 1'b0, runm = 1'b0, ccw = 1'b0, hall = 1'b0, alm = 1'b0;
  logic [3:0] code = 4'h0;
  logic [24:0] func = 25'h0;
  logic [4:0] opn = 5'h0;
  logic [2:0] no;
  logic [13:0] s_spd, c_spd;
  logic [15:0] s_ramp;
  logic [7:0] s_trq;
  logic rq, den, aout;
  logic [4:0] cls, last;
  logic [31:0] seed = 32'h8e58;  // lfsr state
  logic [37:0] tbl[8];  // what the table should hold
  logic [4:0] fn_tab[13] = '{FN_UNUSED, FN_ALARM, FN_ENERGIZED, FN_REACHED, FN_OVER,
    FN_ALARM_PULSE, FN_ENERGIZED_OR_ALARM, FN_RUN, FN_DIR, FN_BRAKE, FN_REACHED_MOVING,
    FN_REACHED_OR_OVER, 5'h09};
  int cyc = 0;
  int fails = 0;
  int tests_run = 0;
  int r0 = 0;  // rises on output 0
  int r1 = 0;  // rises on output 1
  always #50 clk = ~clk;
  dif_ctrl_model i_dif_ctrl_model (.clk(clk), .want_no(want_no), .want_run(want_run),
    .use_net(use_net), .sel0(sel0), .sel1(sel1), .sel2(sel2), .run_io(run_io),
    .run_net(run_net), .from_net(from_net));
  dif_top #(.ALM_HALF_CYC(4), .ALM_GAP_CYC(10)) i_dif_top (.CLK(clk), .RST(rst),
    .INDEX_SEL_BIT0(sel0), .INDEX_SEL_BIT1(sel1), .INDEX_SEL_BIT2(sel2), .DATA_WR(wr),
    .DATA_WR_NO(wr_no), .DATA_WR_SPEED(wr_set[37:24]), .DATA_WR_RAMP(wr_set[23:8]),
    .DATA_WR_TORQUE(wr_set[7:0]), .CMD_SOURCE(src), .ONBOARD_POTENTIOMETER(pot),
    .ANALOG_SPEED(ana), .RUN_CMD_IO(run_io), .RUN_CMD_NET(run_net), .RUN_FROM_NET(from_net),
    .MOTOR_ENERGIZED(ener), .MOTOR_RUNNING(runm), .DIR_CCW(ccw), .HALL_EDGE(hall),
    .MEAS_SPEED(meas), .REACH_BAND(band), .OVER_SPEED(over), .ALARM_PRESENT(alm),
    .ALARM_CODE(code), .OUT_FUNC(func), .OUT_ACTIVE_OPEN(opn), .DATA_NO(no),
    .SEL_SPEED(s_spd), .SEL_RAMP(s_ramp), .SEL_TORQUE(s_trq), .CMD_SPEED(c_spd),
    .RUN_REQUEST(rq), .MOTOR_DRIVE_EN(den), .ALARM_ACTIVE_OUTPUT(aout), .OUT_CLOSED(cls));
  task automatic check(input logic [37:0] got, input logic [37:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic note(input int lag, input int kind, input logic [37:0] val);
    notes.push_back('{cyc + lag, kind, val});
  endtask : note
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // counts cycles and edges; compares each note once its cycle comes
  always @(negedge clk) begin
    cyc = cyc + 1;
    r0 = r0 + int'(cls[0] && !last[0]);
    r1 = r1 + int'(cls[1] && !last[1]);
    last = cls;
    while (notes.size() > 0 && notes[0].cyc <= cyc) begin
      case (notes[0].kind)
        0: check(38'(no), notes[0].val);
        1: check({s_spd, s_ramp, s_trq}, notes[0].val);
        2: check(38'(c_spd), notes[0].val);
        3: check(38'(cls), notes[0].val);
        4: check(38'({rq, den, aout}), notes[0].val);
        default: check(38'({16'(r0), 16'(r1)}), notes[0].val);
      endcase
      void'(notes.pop_front());
    end
  end
  // hang guard: a run this long means something stalled
  initial begin
    repeat (5000) @(posedge clk);
    fails = fails + 1;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tbl[i] = 38'({rnd(), rnd()});
      wr <= 1'b1;
      wr_no <= 3'(i);
      wr_set <= tbl[i];
    end
    @(posedge clk);
    wr <= 1'b0;
    src <= 3'h2;
    // out of order so a swapped select bit shows
    for (int i = 0; i < 8; i++) begin
      logic [2:0] k;
      @(posedge clk);
      k = 3'(i) ^ 3'h5;
      want_no <= k;
      note(5, 0, 38'(k));
      note(5, 1, tbl[k]);
      note(6, 2, 38'(tbl[k][37:24]));
      tick(7);
    end
    $display("select test done");
    for (int i = 0; i < 39; i++) begin
      logic [31:0] r;
      logic [4:0] f;
      logic [13:0] m;
      logic [13:0] mv;
      logic [4:0] st;
      logic a, s, rc, ov;
      int d;
      @(posedge clk);
      r = rnd();
      f = fn_tab[i % 13];
      m = 14'(r[12:0]) + 14'h10;
      mv = (r[22] && r[23]) ? 14'h0 : m + 14'(int'(r[15:13]) - 4);
      d = int'(mv) - int'(m);
      a = r[0] && f != FN_ALARM_PULSE && f != FN_ENERGIZED_OR_ALARM;
      rc = r[26] && d <= int'(r[18:16]) && -d <= int'(r[18:16]);
      ov = r[24] && mv != 14'h0;
      meas <= mv;
      over <= r[24] ? mv - 14'h1 : mv;
      band <= 14'(r[18:16]);
      src <= r[25] ? SRC_ANALOG : SRC_POT;
      pot <= r[25] ? ~m : m;
      ana <= r[25] ? m : ~m;
      {ccw, ener, runm} <= r[28:26];
      want_run <= r[29];
      use_net <= r[30];
      alm <= a;
      opn <= r[5:1];
      func <= {5{f}};
      case (f)
        FN_ALARM: s = a;
        FN_ENERGIZED, FN_ENERGIZED_OR_ALARM: s = r[27];
        FN_REACHED: s = rc;
        FN_OVER: s = ov;
        FN_RUN: s = r[26];
        FN_DIR: s = r[26] && r[28];
        FN_BRAKE: s = r[27] && !a;
        FN_REACHED_MOVING: s = mv != 14'h0 && rc;
        FN_REACHED_OR_OVER: s = r[29] ? rc : ov && rc;
        default: s = 1'b0;
      endcase
      st = {5{s}} ^ r[5:1];
      if (f == FN_BRAKE) begin
        st[2:0] = r[3:1];  // low-current outputs cannot drive the brake
      end
      note(7, 2, 38'(m));
      note(7, 3, 38'(st));
      note(7, 4, 38'({r[29], r[29] && !a, a}));
      tick(8);
    end
    $display("function test done");
    alm <= 1'b0;
    func <= {5{FN_SPEED_PULSE}};
    tick(3);
    r0 = 0;
    r1 = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      hall <= i < 72 && i % 3 == 0;
    end
    note(0, 5, 38'({16'd12, 16'd12}));
    $display("speed pulse test done");
    func <= {15'h0, FN_ENERGIZED_OR_ALARM, FN_ALARM_PULSE};
    opn <= 5'h00;
    ener <= 1'b0;
    code <= 4'h3;
    tick(3);
    r0 = 0;
    r1 = 0;
    alm <= 1'b1;
    tick(32);
    note(0, 5, 38'({16'd3, 16'd3}));
    alm <= 1'b0;
    tick(3);
    $display("alarm pulse test done");
    end_sim();
  end
endmodule : test_dif_top
